//--- src/sfd_detector.sv
// supply fault detector channels: thresholds, hysteresis, filters, digital inputs
// Function
// RULE1 - eight channels: one high-voltage, three low-voltage, four dual-function
// RULE2 - a dual-function channel is either analog detector or digital input, never both
// RULE3 - each detector flags undervoltage, overvoltage or out-of-window
// RULE4 - trip level is range bottom plus span times 8-bit code over 255
// RULE5 - four ranges: 0.573/0.802, 1.25/1.75, 2.5/3.5, 6.0/8.4 volts
// RULE6 - high-voltage upper two ranges, low-voltage lower three, dual lowest only
// RULE7 - hysteresis is span times 5-bit code over 255
// RULE8 - hysteresis applies only while fault is active, widening the clear level
// RULE9 - comparisons run continuously, no sampling request needed
// RULE10 - each channel ends in a glitch filter of zero to 100 us
// RULE11 - pulses shorter than timeout are dropped; passed edges delayed by timeout
// RULE12 - digital input in level mode follows input, edge mode emits timed pulse
// RULE13 - timeout and pulse width are clock tick counters needing stable input
`timescale 1ns/100ps
`include "sfd_regs.svh"
module sfd_detector (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0][15:0] chan_mv_in,
  input wire logic [7:0][1:0] range_sel_in,
  input wire logic [7:0][1:0] fault_mode_in,
  input wire logic [7:0][7:0] uv_code_in,
  input wire logic [7:0][7:0] ov_code_in,
  input wire logic [7:0][4:0] hyst_code_in,
  input wire logic [7:0][6:0] glitch_us_in,
  input wire logic [3:0] dual_dig_sel_in,
  input wire logic [3:0] dual_pin_in,
  input wire logic [3:0] edge_mode_in,
  input wire logic [3:0][6:0] pulse_us_in,
  output logic [7:0] fault_out,
  output logic [7:0] range_err_out,
  output logic [3:0] dig_out
);
  sfd_pkg::sfd_state_s st_q;
  sfd_pkg::sfd_state_s st_d;
  logic [7:0] dsel8;
  logic [7:0] pin8;
  logic [7:0] raw_w;
  logic [7:0] filt_w;

  // RULE2 digital select only on dual channels
  assign dsel8 = {dual_dig_sel_in, `SFD_RST_DUAL};
  assign pin8 = {dual_pin_in, `SFD_RST_DUAL};

  // RULE6 legal range check
  function automatic logic range_bad(input int ch, input logic [1:0] sel);
    logic bad;
    bad = 1'b0;
    if (ch == `SFD_HV_CH) begin
      bad = (sel < 2'h2);
    end else if (ch < `SFD_FIRST_DUAL) begin
      bad = (sel == 2'h3);
    end else begin
      bad = (sel != 2'h0);
    end
    return bad;
  endfunction

  // RULE6 illegal range falls to nearest legal one
  function automatic logic [1:0] range_fix(input int ch, input logic [1:0] sel);
    logic [1:0] r;
    r = sel;
    if (ch == `SFD_HV_CH) begin
      if (sel < 2'h2) begin
        r = 2'h2;
      end
    end else if (ch < `SFD_FIRST_DUAL) begin
      if (sel == 2'h3) begin
        r = 2'h2;
      end
    end else begin
      r = 2'h0;
    end
    return r;
  endfunction

  // RULE5 range bottom table
  function automatic logic [31:0] range_bot(input logic [1:0] r);
    logic [31:0] b;
    b = `SFD_R0_BOT_MV;
    unique case (r)
      2'h0: b = `SFD_R0_BOT_MV;
      2'h1: b = `SFD_R1_BOT_MV;
      2'h2: b = `SFD_R2_BOT_MV;
      2'h3: b = `SFD_R3_BOT_MV;
    endcase
    return b;
  endfunction

  // RULE5 range span table
  function automatic logic [31:0] range_span(input logic [1:0] r);
    logic [31:0] s;
    s = `SFD_R0_SPAN_MV;
    unique case (r)
      2'h0: s = `SFD_R0_SPAN_MV;
      2'h1: s = `SFD_R1_SPAN_MV;
      2'h2: s = `SFD_R2_SPAN_MV;
      2'h3: s = `SFD_R3_SPAN_MV;
    endcase
    return s;
  endfunction

  // RULE4 trip level from code
  function automatic logic [31:0] trip_mv(input logic [1:0] r, input logic [7:0] n);
    return range_bot(r) + (range_span(r) * {24'h000000, n}) / `SFD_CODE_FS;
  endfunction

  // RULE7 hysteresis from code
  function automatic logic [31:0] hyst_mv(input logic [1:0] r, input logic [4:0] n);
    return (range_span(r) * {27'h0, n}) / `SFD_CODE_FS;
  endfunction

  // RULE13 microseconds to clock ticks, capped at 100 us
  function automatic logic [10:0] us_to_cyc(input logic [6:0] us);
    logic [6:0] u;
    logic [31:0] c;
    u = (us > `SFD_MAX_TMO_US) ? `SFD_MAX_TMO_US : us;
    c = {25'h0, u} * (`SFD_NS_PER_US / `SFD_CLK_PERIOD_NS);
    return c[10:0];
  endfunction

  // RULE3 condition select
  function automatic logic sel_fault(input logic [1:0] m, input logic uv, input logic ov);
    logic f;
    f = 1'b0;
    unique case (m)
      sfd_pkg::SFD_MODE_UV: f = uv;
      sfd_pkg::SFD_MODE_OV: f = ov;
      sfd_pkg::SFD_MODE_WIN: f = uv | ov;
      sfd_pkg::SFD_MODE_OFF: f = 1'b0;
    endcase
    return f;
  endfunction

  // RULE1 eight channels each with a filter
  genvar g;
  generate
    for (g = 0; g < `SFD_NUM_CH; g++) begin : gen_ch
      sfd_filt_if flt ();
      // RULE2 pin or comparator feeds the filter
      assign flt.raw = dsel8[g] ? pin8[g] : sel_fault(fault_mode_in[g], st_q.uv[g], st_q.ov[g]);
      // RULE10 programmable timeout
      assign flt.tmo = us_to_cyc(glitch_us_in[g]);
      assign filt_w[g] = flt.filt;
      assign raw_w[g] = flt.raw;
      sfd_glitch_filter u_filt (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .fi(flt.filt_side)
      );
    end
  endgenerate

  always_comb begin
    logic [1:0] rng;
    logic [31:0] v;
    logic [31:0] uv_th;
    logic [31:0] ov_th;
    logic [31:0] hy;
    logic f;
    logic [10:0] pw;
    rng = 2'h0;
    v = '0;
    uv_th = '0;
    ov_th = '0;
    hy = '0;
    f = 1'b0;
    pw = '0;
    st_d = st_q;
    for (int i = 0; i < `SFD_NUM_CH; i++) begin
      rng = range_fix(i, range_sel_in[i]);
      v = {16'h0000, chan_mv_in[i]};
      uv_th = trip_mv(rng, uv_code_in[i]);
      ov_th = trip_mv(rng, ov_code_in[i]);
      hy = hyst_mv(rng, hyst_code_in[i]);
      st_d.rerr[i] = !dsel8[i] && range_bad(i, range_sel_in[i]);
      if (dsel8[i]) begin
        // RULE2 analog detector idle in digital mode
        st_d.uv[i] = 1'b0;
        st_d.ov[i] = 1'b0;
        st_d.fault[i] = 1'b0;
      end else begin
        // RULE9 continuous compare
        // RULE8 undervoltage clears above threshold plus hysteresis
        if (!st_q.uv[i]) begin
          st_d.uv[i] = (v < uv_th);
        end else begin
          st_d.uv[i] = !(v > (uv_th + hy));
        end
        // RULE8 overvoltage clears below threshold minus hysteresis
        if (!st_q.ov[i]) begin
          st_d.ov[i] = (v > ov_th);
        end else begin
          st_d.ov[i] = !((v + hy) < ov_th);
        end
        // RULE10 filtered result drives fault
        st_d.fault[i] = filt_w[i];
      end
    end
    for (int j = 0; j < `SFD_NUM_DUAL; j++) begin
      f = filt_w[j + `SFD_FIRST_DUAL];
      pw = us_to_cyc(pulse_us_in[j]);
      st_d.dig_prev[j] = f;
      if (!dual_dig_sel_in[j]) begin
        st_d.pcnt[j] = '0;
        st_d.dig[j] = 1'b0;
      end else if (!edge_mode_in[j]) begin
        // RULE12 level mode follows filtered pin
        st_d.pcnt[j] = '0;
        st_d.dig[j] = f;
      end else begin
        // RULE12 edge mode timed pulse
        if ((f != st_q.dig_prev[j]) && (pw != '0)) begin
          st_d.pcnt[j] = pw;
        end else if (st_q.pcnt[j] != '0) begin
          st_d.pcnt[j] = st_q.pcnt[j] - 11'h001;
        end
        st_d.dig[j] = (st_d.pcnt[j] != '0);
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fault_out = st_q.fault;
  assign range_err_out = st_q.rerr;
  assign dig_out = st_q.dig;
endmodule

//--- src/sfd_regs.svh
// constants for the supply fault detector logic
`ifndef SFD_REGS_SVH
`define SFD_REGS_SVH
// clock period and time units
`define SFD_CLK_PERIOD_NS 32'h00000032
`define SFD_NS_PER_US 32'h000003e8
// longest glitch filter timeout and edge pulse width, in us (100)
`define SFD_MAX_TMO_US 7'h64
// counter width for up to 100 us of 50 ns ticks
`define SFD_CNT_W 11
// channel counts
`define SFD_NUM_CH 8
`define SFD_NUM_DUAL 4
`define SFD_FIRST_DUAL 4
`define SFD_HV_CH 0
// range bottoms and spans in mV: 573/802, 1250/1750, 2500/3500, 6000/8400
`define SFD_R0_BOT_MV 32'h0000023d
`define SFD_R0_SPAN_MV 32'h00000322
`define SFD_R1_BOT_MV 32'h000004e2
`define SFD_R1_SPAN_MV 32'h000006d6
`define SFD_R2_BOT_MV 32'h000009c4
`define SFD_R2_SPAN_MV 32'h00000dac
`define SFD_R3_BOT_MV 32'h00001770
`define SFD_R3_SPAN_MV 32'h000020d0
// code full scale
`define SFD_CODE_FS 32'h000000ff
// reset values
`define SFD_RST_CH 8'h00
`define SFD_RST_DUAL 4'h0
`endif

//--- src/sfd_pkg.sv
// types for the supply fault detector logic
package sfd_pkg;
  typedef enum logic [1:0] {
    SFD_MODE_UV = 2'h0,
    SFD_MODE_OV = 2'h1,
    SFD_MODE_WIN = 2'h3,
    SFD_MODE_OFF = 2'h2
  } sfd_mode_e;

  typedef logic [10:0] sfd_cnt_t;

  typedef struct packed {
    logic [7:0] uv;
    logic [7:0] ov;
    logic [7:0] fault;
    logic [7:0] rerr;
    logic [3:0] dig_prev;
    logic [3:0] dig;
    logic [3:0][10:0] pcnt;
  } sfd_state_s;

  typedef struct packed {
    logic filt;
    logic [10:0] cnt;
  } sfd_filt_state_s;
endpackage

//--- src/sfd_filt_if.sv
// link between a channel and its glitch filter
`timescale 1ns/100ps
interface sfd_filt_if;
  logic raw;
  logic [10:0] tmo;
  logic filt;
  modport chan (output raw, output tmo, input filt);
  modport filt_side (input raw, input tmo, output filt);
endinterface

//--- src/sfd_glitch_filter.sv
// glitch filter: output follows input only after it stays stable for the timeout
`timescale 1ns/100ps
`include "sfd_regs.svh"
module sfd_glitch_filter (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  sfd_filt_if.filt_side fi
);
  sfd_pkg::sfd_filt_state_s st_q;
  sfd_pkg::sfd_filt_state_s st_d;

  always_comb begin
    st_d = st_q;
    // RULE13 stable for full count
    if (fi.raw == st_q.filt) begin
      st_d.cnt = '0;
    // RULE11 suppress short pulses
    end else if ((st_q.cnt + 11'h001) >= fi.tmo) begin
      st_d.filt = fi.raw;
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + 11'h001;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fi.filt = st_q.filt;
endmodule

//--- verif/sfd_detector_checker.sv
// assertions on the supply fault detector ports
`timescale 1ns/100ps
module sfd_detector_checker (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0][15:0] chan_mv_in,
  input wire logic [7:0][1:0] range_sel_in,
  input wire logic [7:0][1:0] fault_mode_in,
  input wire logic [7:0][6:0] glitch_us_in,
  input wire logic [3:0] dual_dig_sel_in,
  input wire logic [3:0] dual_pin_in,
  input wire logic [3:0] edge_mode_in,
  input wire logic [3:0][6:0] pulse_us_in,
  input wire logic [7:0] fault_out,
  input wire logic [7:0] range_err_out,
  input wire logic [3:0] dig_out
);
  logic [10:0] hi_q;
  // length of the current high run on the edge channel
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hi_q <= 11'h000;
    end else if (dig_out[1]) begin
      hi_q <= hi_q + 11'h001;
    end else begin
      hi_q <= 11'h000;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_deep_uv;
    (fault_mode_in[1] == sfd_pkg::SFD_MODE_UV && glitch_us_in[1] == 7'h00 && range_sel_in[1] == 2'h2
      && chan_mv_in[1] < 16'h09c4) [*4];
  endsequence
  sequence s_deep_ov;
    (fault_mode_in[0] == sfd_pkg::SFD_MODE_OV && glitch_us_in[0] == 7'h00 && range_sel_in[0] == 2'h3
      && chan_mv_in[0] > 16'h3840) [*4];
  endsequence
  sequence s_level_high;
    (dual_dig_sel_in[2] && !edge_mode_in[2] && glitch_us_in[6] == 7'h00 && dual_pin_in[2]) [*3];
  endsequence
  property p_deep_uv;
    s_deep_uv |-> fault_out[1];
  endproperty
  property p_deep_ov;
    s_deep_ov |-> fault_out[0];
  endproperty
  property p_range_hv;
    range_sel_in[0] < 2'h2 |=> range_err_out[0];
  endproperty
  property p_range_lv;
    1'b1 |=> range_err_out[3] == $past(range_sel_in[3] == 2'h3);
  endproperty
  property p_range_dual;
    !dual_dig_sel_in[0] && range_sel_in[4] != 2'h0 |=> range_err_out[4];
  endproperty
  property p_dig_off;
    !dual_dig_sel_in[0] |=> !dig_out[0];
  endproperty
  property p_dig_no_fault;
    dual_dig_sel_in[2] ##1 dual_dig_sel_in[2] |-> !fault_out[6];
  endproperty
  property p_level;
    s_level_high |-> dig_out[2];
  endproperty
  property p_edge_pulse;
    $fell(dig_out[1]) && edge_mode_in[1] && pulse_us_in[1] == 7'h01 && dual_dig_sel_in[1] |-> hi_q == 11'h014;
  endproperty
  a_deep_uv: assert property (p_deep_uv) else $error("undervoltage not flagged");
  a_deep_ov: assert property (p_deep_ov) else $error("overvoltage not flagged");
  a_range_hv: assert property (p_range_hv) else $error("high-voltage range not flagged");
  a_range_lv: assert property (p_range_lv) else $error("low-voltage range flag wrong");
  a_range_dual: assert property (p_range_dual) else $error("dual range not flagged");
  a_dig_off: assert property (p_dig_off) else $error("digital output in analog mode");
  a_dig_no_fault: assert property (p_dig_no_fault) else $error("fault in digital mode");
  a_level: assert property (p_level) else $error("level mode not forwarded");
  a_edge_pulse: assert property (p_edge_pulse) else $error("edge pulse width wrong");
endmodule

//--- verif/sfd_rail_model.sv
// behavioural model of the monitored supply rails
`timescale 1ns/100ps
module sfd_rail_model (
  input wire logic ref_clk_in,
  input wire logic [7:0][15:0] target_mv_in,
  output logic [7:0][15:0] rail_mv_out = {8{16'h1f40}}
);
  // rails settle one tick after a new level is commanded
  always @(posedge ref_clk_in) begin
    rail_mv_out <= target_mv_in;
  end
endmodule

//--- verif/tb.sv
// self-checking testbench for the supply fault detector
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0][15:0] mv_tgt = {8{16'h1f40}};
  logic [7:0][15:0] mv;
  logic [7:0][1:0] rng = 16'h00ab;
  logic [7:0][1:0] md = 16'h0000;
  logic [7:0][7:0] uvc = 64'h0000_0000_0000_b600;
  logic [7:0][7:0] ovc = 64'h0;
  logic [7:0][4:0] hy = 40'h0000000140;
  logic [7:0][6:0] gl = 56'h00000000200000;
  logic [3:0] dsel = 4'h0;
  logic [3:0] pin = 4'h0;
  logic [3:0] edg = 4'h2;
  logic [3:0][6:0] pw = 28'h0000080;
  logic [7:0] flt;
  logic [7:0] rerr;
  logic [3:0] dig;
  int fails = 0;
  int total_checks = 0;
  int n;
  sfd_rail_model i_rail (.ref_clk_in(clk), .target_mv_in(mv_tgt), .rail_mv_out(mv));
  sfd_detector i_dut (.ref_clk_in(clk), .rst_b_in(rst_b), .chan_mv_in(mv), .range_sel_in(rng),
    .fault_mode_in(md), .uv_code_in(uvc), .ov_code_in(ovc), .hyst_code_in(hy), .glitch_us_in(gl),
    .dual_dig_sel_in(dsel), .dual_pin_in(pin), .edge_mode_in(edg), .pulse_us_in(pw),
    .fault_out(flt), .range_err_out(rerr), .dig_out(dig));
  initial begin
    forever #25 clk = ~clk;
  end
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task chk(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task drive(input int ch, input logic [15:0] v);
    @(posedge clk);
    mv_tgt[ch] <= v;
  endtask
  task step(input int ch, input logic [15:0] v, input logic e);
    drive(ch, v);
    tick(6);
    chk({7'h0, e}, {7'h0, flt[ch]});
  endtask
  task pulse_len(output int c);
    c = 0;
    repeat (40) begin
      tick(1);
      if (dig[1] === 1'b1) c++;
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    tick(2);
    step(1, 16'h1386, 1'b0);
    step(1, 16'h07d0, 1'b1);
    step(1, 16'h140f, 1'b1);
    step(1, 16'h1410, 1'b0);
    step(1, 16'h1385, 1'b1);
    $display("undervoltage test done");
    @(posedge clk);
    md[0] <= 2'h1;
    ovc[0] <= 8'hb6;
    step(0, 16'h2edc, 1'b1);
    step(0, 16'h2edb, 1'b1);
    step(0, 16'h2eda, 1'b0);
    step(0, 16'h3a98, 1'b1);
    step(0, 16'h1f40, 1'b0);
    @(posedge clk);
    md[0] <= 2'h3;
    step(0, 16'h176f, 1'b1);
    step(0, 16'h1f40, 1'b0);
    @(posedge clk);
    md[1] <= 2'h2;
    tick(6);
    chk(8'h00, {7'h0, flt[1]});
    $display("overvoltage, window and off test done");
    drive(3, 16'h07d0);
    tick(10);
    drive(3, 16'h1f40);
    tick(30);
    chk(8'h00, {7'h0, flt[3]});
    drive(3, 16'h07d0);
    tick(12);
    chk(8'h00, {7'h0, flt[3]});
    tick(20);
    chk(8'h01, {7'h0, flt[3]});
    $display("glitch filter test done");
    @(posedge clk);
    rng <= 16'h15e9;
    dsel <= 4'h6;
    pin <= 4'h5;
    mv_tgt[6] <= 16'h0064;
    tick(6);
    chk(8'h19, rerr);
    chk(8'h00, flt & 8'h40);
    chk(8'h04, {4'h0, dig});
    @(posedge clk);
    pin[1] <= 1'b1;
    pulse_len(n);
    chk(8'h14, 8'(n));
    @(posedge clk);
    pin[1] <= 1'b0;
    pulse_len(n);
    chk(8'h14, 8'(n));
    $display("range and digital test done");
    give_verdict();
  end
endmodule
bind sfd_detector sfd_detector_checker i_chk (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
  .chan_mv_in(chan_mv_in), .range_sel_in(range_sel_in), .fault_mode_in(fault_mode_in),
  .glitch_us_in(glitch_us_in), .dual_dig_sel_in(dual_dig_sel_in), .dual_pin_in(dual_pin_in),
  .edge_mode_in(edge_mode_in), .pulse_us_in(pulse_us_in), .fault_out(fault_out),
  .range_err_out(range_err_out), .dig_out(dig_out));
